// ---- common/iop_pkg.sv ----
/*
 * Shared constants for the general-purpose I/O port block: register
 * indices in the data memory window, reset values, writable-bit masks,
 * field positions and source-current group maps.
 * Assumes the CPU data memory decoder presents a local 8-bit index.
 */
`default_nettype none

package iop_pkg;

	// Widths
	localparam int IOP_DW = 8;
	localparam int IOP_AW = 8;
	localparam int IOP_LVW = 16;

	// Register indices in the local data memory window
	localparam logic [7:0] IOP_OFS_PA_DATA = 8'h00;
	localparam logic [7:0] IOP_OFS_PA_DIR = 8'h01;
	localparam logic [7:0] IOP_OFS_PA_PULL = 8'h02;
	localparam logic [7:0] IOP_OFS_PA_WAKE = 8'h03;
	localparam logic [7:0] IOP_OFS_PB_DATA = 8'h04;
	localparam logic [7:0] IOP_OFS_PB_DIR = 8'h05;
	localparam logic [7:0] IOP_OFS_PB_PULL = 8'h06;
	localparam logic [7:0] IOP_OFS_PC_DATA = 8'h07;
	localparam logic [7:0] IOP_OFS_PC_DIR = 8'h08;
	localparam logic [7:0] IOP_OFS_PC_PULL = 8'h09;
	localparam logic [7:0] IOP_OFS_PD_DIR = 8'h0A;
	localparam logic [7:0] IOP_OFS_PD_STRENGTH = 8'h0B;
	localparam logic [7:0] IOP_OFS_SRC_LOW = 8'h0C;
	localparam logic [7:0] IOP_OFS_SRC_HIGH = 8'h0D;

	// Reset values
	localparam logic [7:0] IOP_RST_DATA = 8'hFF;
	localparam logic [7:0] IOP_RST_DIR = 8'hFF;
	localparam logic [7:0] IOP_RST_ZERO = 8'h00;
	localparam logic [7:0] IOP_RST_PD_DIR = 8'h03;

	// Writable-bit masks; bits outside read as zero
	localparam logic [7:0] IOP_MASK_FULL = 8'hFF;
	localparam logic [7:0] IOP_MASK_PD_DIR = 8'h03;
	localparam logic [7:0] IOP_MASK_NIBBLE = 8'h0F;

	// Port D pull strength fields
	localparam int IOP_PD1_STR_LSB = 2;
	localparam int IOP_PD0_STR_LSB = 0;

	// Source current select fields (low register)
	localparam int IOP_SRC_PB74_LSB = 6;
	localparam int IOP_SRC_PB0_LSB = 4;
	localparam int IOP_SRC_PA76_LSB = 2;
	localparam int IOP_SRC_PA30_LSB = 0;
	// Source current select fields (high register)
	localparam int IOP_SRC_PC74_LSB = 2;
	localparam int IOP_SRC_PC30_LSB = 0;

	// Pins covered by each source current group
	localparam logic [7:0] IOP_GRP_PB74 = 8'hF0;
	localparam logic [7:0] IOP_GRP_PB0 = 8'h01;
	localparam logic [7:0] IOP_GRP_PA76 = 8'hC0;
	localparam logic [7:0] IOP_GRP_PA30 = 8'h0F;
	localparam logic [7:0] IOP_GRP_PC74 = 8'hF0;
	localparam logic [7:0] IOP_GRP_PC30 = 8'h0F;

	// Pull strength codes
	localparam logic [1:0] IOP_STR_OFF = 2'h0;

endpackage

`default_nettype wire

// ---- hdl/iop_pin_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs, with a high-to-low
 * edge detector on the synchronised level.
 * Assumes pins are asynchronous to clk_in; reset is synchronous, active high.
 */
`default_nettype none

module iop_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Raw pins
	input wire logic [WIDTH-1:0] pin_in,
	// Synchronised level and falling-edge pulse
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] fall_out
);

	logic [WIDTH-1:0] meta_q; // First stage, read only by the second
	logic [WIDTH-1:0] sync_q; // Second stage, safe to use
	logic [WIDTH-1:0] prev_q; // Previous synchronised level

	// Pins idle high with pull-ups, so reset to one avoids a false edge
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_out = sync_q;
	assign fall_out = prev_q & ~sync_q;

endmodule

`default_nettype wire

// ---- hdl/iop_port.sv ----
/*
 * General-purpose I/O port logic: data latches, direction, pull-high
 * enables, port D pull strength, port A wake-up and source current
 * level selection, reached through a simple data memory port.
 * Assumes the CPU supplies single-cycle read and write strobes on clk_in,
 * that pin-shared function selection lives outside, and that the pad
 * ring resolves pins from the pin, output and enable signals.
 */
`default_nettype none

// Notes on behaviour
// (RL1) Output latch holds until rewritten; inputs unlatched
// (RL2) Per-pin pull-high bit, 1 connects pull
// (RL3) Pull acts only for digital input or NMOS
// (RL4) Bits 3:2 pick line D1 pull strength
// (RL5) Bits 1:0 pick line D0 pull strength
// (RL6) Port A falling edge wakes halted core
// (RL7) Eight port A wake-up enable bits
// (RL8) Wake only for GPIO input while halted
// (RL9) Direction 1 is input, 0 CMOS output
// (RL10) Output pin reads latch when read-control is 0
// (RL11) Source current acts only on CMOS outputs
// (RL12) Four source current levels per pin group
// (RL13) Unimplemented bits read zero, ignore writes
// (RL14) Software keeps PHY-line wake bits unchanged
// (RL15) Software sets PHY line directions after power-on
// (RL16) Source code 00 weakest to 11 strongest
// (RL17) Reset: inputs, pulls, wake, source cleared
// (RL18) Writes to input pins still load latch
module iop_port (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Data memory port
	input wire logic [iop_pkg::IOP_AW-1:0] mem_addr_in,
	input wire logic mem_wr_in,
	input wire logic mem_rd_in,
	input wire logic [iop_pkg::IOP_DW-1:0] mem_wdata_in,
	output logic [iop_pkg::IOP_DW-1:0] mem_rdata_out,
	// Core state
	input wire logic halted_in,
	input wire logic input_read_control_in,
	// Pin-shared function state per pin
	input wire logic [7:0] port_a_gpio_sel_in,
	input wire logic [7:0] port_a_open_drain_in,
	input wire logic [7:0] port_b_gpio_sel_in,
	input wire logic [7:0] port_b_open_drain_in,
	input wire logic [7:0] port_c_gpio_sel_in,
	input wire logic [7:0] port_c_open_drain_in,
	// Port A pins
	input wire logic [7:0] port_a_pin_in,
	output logic [7:0] port_a_pin_out,
	output logic [7:0] port_a_pin_oe_out,
	// Port B pins
	input wire logic [7:0] port_b_pin_in,
	output logic [7:0] port_b_pin_out,
	output logic [7:0] port_b_pin_oe_out,
	// Port C pins
	input wire logic [7:0] port_c_pin_in,
	output logic [7:0] port_c_pin_out,
	output logic [7:0] port_c_pin_oe_out,
	// Pull-high controls to the pads
	output logic [7:0] port_a_pull_high_out,
	output logic [7:0] port_b_pull_high_out,
	output logic [7:0] port_c_pull_high_out,
	// Port D lines toward the power delivery phy
	output logic [1:0] port_d_pin_direction_out,
	output logic [1:0] port_d0_pull_strength_out,
	output logic [1:0] port_d1_pull_strength_out,
	// Source current level per pin, two bits each
	output logic [iop_pkg::IOP_LVW-1:0] port_a_drive_level_out,
	output logic [iop_pkg::IOP_LVW-1:0] port_b_drive_level_out,
	output logic [iop_pkg::IOP_LVW-1:0] port_c_drive_level_out,
	// Wake request to the power manager
	output logic wake_out
);
	import iop_pkg::*;

	// Merge a masked write into a register value
	function automatic logic [7:0] masked_write(input logic [7:0] cur,
			input logic [7:0] wdata, input logic [7:0] mask);
		masked_write = (wdata & mask) | (cur & ~mask);
	endfunction

	// Read-back of a port data register, bit by bit
	function automatic logic [7:0] port_read(input logic [7:0] dir,
			input logic [7:0] latch, input logic [7:0] pin, input logic ctrl);
		logic [7:0] use_pin;
		use_pin = dir | {8{ctrl}};
		port_read = (pin & use_pin) | (latch & ~use_pin);
	endfunction

	// Spread a two-bit level over the pins of a group
	function automatic logic [15:0] spread(input logic [1:0] lvl,
			input logic [7:0] grp);
		logic [15:0] res;
		res = '0;
		for (int i = 0; i < 8; i++) begin
			if (grp[i]) begin
				res[2*i +: 2] = lvl;
			end
		end
		spread = res;
	endfunction

	// Double each bit of a pin mask to cover a two-bit field
	function automatic logic [15:0] widen(input logic [7:0] m);
		logic [15:0] res;
		res = '0;
		for (int i = 0; i < 8; i++) begin
			res[2*i +: 2] = {2{m[i]}};
		end
		widen = res;
	endfunction

	// Software-visible registers
	logic [7:0] pa_data_q, pb_data_q, pc_data_q; // Output latches
	logic [7:0] pa_dir_q, pb_dir_q, pc_dir_q; // 1 = input
	logic [7:0] pa_pull_q, pb_pull_q, pc_pull_q; // Pull-high enables
	logic [7:0] pa_wake_q; // Port A wake-up enables
	logic [7:0] pd_dir_q; // Port D direction, two bits live
	logic [7:0] pd_str_q; // Port D pull strength, nibble live
	logic [7:0] src_low_q; // Source current fields, ports A and B
	logic [7:0] src_high_q; // Source current fields, port C

	// Pad-facing and answer registers
	logic [7:0] pa_pin_q, pb_pin_q, pc_pin_q;
	logic [7:0] pa_oe_q, pb_oe_q, pc_oe_q;
	logic [7:0] pa_pu_q, pb_pu_q, pc_pu_q;
	logic [15:0] pa_lvl_q, pb_lvl_q, pc_lvl_q;
	logic [7:0] rdata_q;
	logic wake_q;

	// Synchronised pin levels
	logic [7:0] pa_sync, pb_sync, pc_sync;
	logic [7:0] pa_fall; // Falling edges on port A

	// Address decode
	wire logic sel_pa_data = mem_addr_in == IOP_OFS_PA_DATA;
	wire logic sel_pa_dir = mem_addr_in == IOP_OFS_PA_DIR;
	wire logic sel_pa_pull = mem_addr_in == IOP_OFS_PA_PULL;
	wire logic sel_pa_wake = mem_addr_in == IOP_OFS_PA_WAKE;
	wire logic sel_pb_data = mem_addr_in == IOP_OFS_PB_DATA;
	wire logic sel_pb_dir = mem_addr_in == IOP_OFS_PB_DIR;
	wire logic sel_pb_pull = mem_addr_in == IOP_OFS_PB_PULL;
	wire logic sel_pc_data = mem_addr_in == IOP_OFS_PC_DATA;
	wire logic sel_pc_dir = mem_addr_in == IOP_OFS_PC_DIR;
	wire logic sel_pc_pull = mem_addr_in == IOP_OFS_PC_PULL;
	wire logic sel_pd_dir = mem_addr_in == IOP_OFS_PD_DIR;
	wire logic sel_pd_str = mem_addr_in == IOP_OFS_PD_STRENGTH;
	wire logic sel_src_low = mem_addr_in == IOP_OFS_SRC_LOW;
	wire logic sel_src_high = mem_addr_in == IOP_OFS_SRC_HIGH;

	// Pin configuration terms
	wire logic [7:0] pa_gpio_in = port_a_gpio_sel_in & pa_dir_q;
	wire logic [7:0] pb_gpio_in = port_b_gpio_sel_in & pb_dir_q;
	wire logic [7:0] pc_gpio_in = port_c_gpio_sel_in & pc_dir_q;
	wire logic [7:0] pa_cmos = port_a_gpio_sel_in & ~pa_dir_q & ~port_a_open_drain_in;
	wire logic [7:0] pb_cmos = port_b_gpio_sel_in & ~pb_dir_q & ~port_b_open_drain_in;
	wire logic [7:0] pc_cmos = port_c_gpio_sel_in & ~pc_dir_q & ~port_c_open_drain_in;

	// Output enables: the pad is driven only by a GPIO output
	wire logic [7:0] pa_oe_d = port_a_gpio_sel_in & ~pa_dir_q; // RL9
	wire logic [7:0] pb_oe_d = port_b_gpio_sel_in & ~pb_dir_q; // RL9
	wire logic [7:0] pc_oe_d = port_c_gpio_sel_in & ~pc_dir_q; // RL9

	// Pull-high gated to digital inputs and open-drain outputs
	wire logic [7:0] pa_pu_d = pa_pull_q & (pa_gpio_in | port_a_open_drain_in); // RL2 RL3
	wire logic [7:0] pb_pu_d = pb_pull_q & (pb_gpio_in | port_b_open_drain_in); // RL2 RL3
	wire logic [7:0] pc_pu_d = pc_pull_q & (pc_gpio_in | port_c_open_drain_in); // RL2 RL3

	// Source current levels, forced to level 0 unless CMOS output
	wire logic [15:0] pa_lvl_raw =
		spread(src_low_q[IOP_SRC_PA30_LSB +: 2], IOP_GRP_PA30) |
		spread(src_low_q[IOP_SRC_PA76_LSB +: 2], IOP_GRP_PA76); // RL12 RL16
	wire logic [15:0] pb_lvl_raw =
		spread(src_low_q[IOP_SRC_PB0_LSB +: 2], IOP_GRP_PB0) |
		spread(src_low_q[IOP_SRC_PB74_LSB +: 2], IOP_GRP_PB74); // RL12 RL16
	wire logic [15:0] pc_lvl_raw =
		spread(src_high_q[IOP_SRC_PC30_LSB +: 2], IOP_GRP_PC30) |
		spread(src_high_q[IOP_SRC_PC74_LSB +: 2], IOP_GRP_PC74); // RL12 RL16
	wire logic [15:0] pa_lvl_d = pa_lvl_raw & widen(pa_cmos); // RL11
	wire logic [15:0] pb_lvl_d = pb_lvl_raw & widen(pb_cmos); // RL11
	wire logic [15:0] pc_lvl_d = pc_lvl_raw & widen(pc_cmos); // RL11

	// Wake: enabled falling edge on a GPIO input while halted
	wire logic wake_d = halted_in &
		(|(pa_fall & pa_wake_q & pa_gpio_in)); // RL6 RL8

	// Read multiplexer; unmapped addresses answer zero
	wire logic [7:0] pa_rd = port_read(pa_dir_q, pa_data_q, pa_sync,
		input_read_control_in); // RL10
	wire logic [7:0] pb_rd = port_read(pb_dir_q, pb_data_q, pb_sync,
		input_read_control_in); // RL10
	wire logic [7:0] pc_rd = port_read(pc_dir_q, pc_data_q, pc_sync,
		input_read_control_in); // RL10
	wire logic [7:0] rdata_d =
		({8{sel_pa_data}} & pa_rd) |
		({8{sel_pa_dir}} & pa_dir_q) |
		({8{sel_pa_pull}} & pa_pull_q) |
		({8{sel_pa_wake}} & pa_wake_q) |
		({8{sel_pb_data}} & pb_rd) |
		({8{sel_pb_dir}} & pb_dir_q) |
		({8{sel_pb_pull}} & pb_pull_q) |
		({8{sel_pc_data}} & pc_rd) |
		({8{sel_pc_dir}} & pc_dir_q) |
		({8{sel_pc_pull}} & pc_pull_q) |
		({8{sel_pd_dir}} & (pd_dir_q & IOP_MASK_PD_DIR)) |
		({8{sel_pd_str}} & (pd_str_q & IOP_MASK_NIBBLE)) |
		({8{sel_src_low}} & src_low_q) |
		({8{sel_src_high}} & (src_high_q & IOP_MASK_NIBBLE)); // RL13

	// Synchronise all pin inputs; port A also yields falling edges
	iop_pin_sync #(
		.WIDTH(8)
	) u_sync_a (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(port_a_pin_in),
		.level_out(pa_sync),
		.fall_out(pa_fall)
	);

	iop_pin_sync #(
		.WIDTH(8)
	) u_sync_b (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(port_b_pin_in),
		.level_out(pb_sync),
		.fall_out()
	);

	iop_pin_sync #(
		.WIDTH(8)
	) u_sync_c (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(port_c_pin_in),
		.level_out(pc_sync),
		.fall_out()
	);

	// Output latches: loaded on any write, even while the pin is an input
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pa_data_q <= IOP_RST_DATA;
			pb_data_q <= IOP_RST_DATA;
			pc_data_q <= IOP_RST_DATA;
		end else if (mem_wr_in) begin
			if (sel_pa_data) begin
				pa_data_q <= mem_wdata_in; // RL1 RL18
			end
			if (sel_pb_data) begin
				pb_data_q <= mem_wdata_in; // RL1 RL18
			end
			if (sel_pc_data) begin
				pc_data_q <= mem_wdata_in; // RL1 RL18
			end
		end
	end

	// Direction registers; every pin starts as an input
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pa_dir_q <= IOP_RST_DIR; // RL17
			pb_dir_q <= IOP_RST_DIR; // RL17
			pc_dir_q <= IOP_RST_DIR; // RL17
			pd_dir_q <= IOP_RST_PD_DIR; // RL17
		end else if (mem_wr_in) begin
			if (sel_pa_dir) begin
				pa_dir_q <= mem_wdata_in; // RL9
			end
			if (sel_pb_dir) begin
				pb_dir_q <= mem_wdata_in; // RL9
			end
			if (sel_pc_dir) begin
				pc_dir_q <= mem_wdata_in; // RL9
			end
			if (sel_pd_dir) begin
				pd_dir_q <= masked_write(pd_dir_q, mem_wdata_in, IOP_MASK_PD_DIR); // RL13
			end
		end
	end

	// Pull-high and wake-up enables
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pa_pull_q <= IOP_RST_ZERO; // RL17
			pb_pull_q <= IOP_RST_ZERO; // RL17
			pc_pull_q <= IOP_RST_ZERO; // RL17
			pa_wake_q <= IOP_RST_ZERO; // RL17
		end else if (mem_wr_in) begin
			if (sel_pa_pull) begin
				pa_pull_q <= mem_wdata_in; // RL2
			end
			if (sel_pb_pull) begin
				pb_pull_q <= mem_wdata_in; // RL2
			end
			if (sel_pc_pull) begin
				pc_pull_q <= mem_wdata_in; // RL2
			end
			if (sel_pa_wake) begin
				pa_wake_q <= mem_wdata_in; // RL7
			end
		end
	end

	// Strength and source current selections; upper nibbles of pd_str_q and src_high_q stay zero
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pd_str_q <= IOP_RST_ZERO; // RL17
			src_low_q <= IOP_RST_ZERO; // RL17
			src_high_q <= IOP_RST_ZERO; // RL17
		end else if (mem_wr_in) begin
			if (sel_pd_str) begin
				pd_str_q <= masked_write(pd_str_q, mem_wdata_in, IOP_MASK_NIBBLE); // RL13
			end
			if (sel_src_low) begin
				src_low_q <= masked_write(src_low_q, mem_wdata_in, IOP_MASK_FULL);
			end
			if (sel_src_high) begin
				src_high_q <= masked_write(src_high_q, mem_wdata_in, IOP_MASK_NIBBLE); // RL13
			end
		end
	end

	// Pad-facing flops; one cycle of latency keeps outputs glitch-free
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pa_pin_q <= IOP_RST_DATA;
			pb_pin_q <= IOP_RST_DATA;
			pc_pin_q <= IOP_RST_DATA;
			pa_oe_q <= IOP_RST_ZERO;
			pb_oe_q <= IOP_RST_ZERO;
			pc_oe_q <= IOP_RST_ZERO;
		end else begin
			pa_pin_q <= pa_data_q; // RL1
			pb_pin_q <= pb_data_q; // RL1
			pc_pin_q <= pc_data_q; // RL1
			pa_oe_q <= pa_oe_d;
			pb_oe_q <= pb_oe_d;
			pc_oe_q <= pc_oe_d;
		end
	end

	// Pull and drive strength flops
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pa_pu_q <= IOP_RST_ZERO;
			pb_pu_q <= IOP_RST_ZERO;
			pc_pu_q <= IOP_RST_ZERO;
			pa_lvl_q <= '0;
			pb_lvl_q <= '0;
			pc_lvl_q <= '0;
		end else begin
			pa_pu_q <= pa_pu_d;
			pb_pu_q <= pb_pu_d;
			pc_pu_q <= pc_pu_d;
			pa_lvl_q <= pa_lvl_d;
			pb_lvl_q <= pb_lvl_d;
			pc_lvl_q <= pc_lvl_d;
		end
	end

	// Read data and wake pulse; reads have no side effects
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_q <= IOP_RST_ZERO;
			wake_q <= 1'b0;
		end else begin
			if (mem_rd_in) begin
				rdata_q <= rdata_d;
			end
			wake_q <= wake_d; // RL6
		end
	end

	// Outputs straight from flops
	assign mem_rdata_out = rdata_q;
	assign port_a_pin_out = pa_pin_q;
	assign port_b_pin_out = pb_pin_q;
	assign port_c_pin_out = pc_pin_q;
	assign port_a_pin_oe_out = pa_oe_q;
	assign port_b_pin_oe_out = pb_oe_q;
	assign port_c_pin_oe_out = pc_oe_q;
	assign port_a_pull_high_out = pa_pu_q;
	assign port_b_pull_high_out = pb_pu_q;
	assign port_c_pull_high_out = pc_pu_q;
	assign port_d_pin_direction_out = pd_dir_q[1:0];
	assign port_d1_pull_strength_out = pd_str_q[IOP_PD1_STR_LSB +: 2]; // RL4
	assign port_d0_pull_strength_out = pd_str_q[IOP_PD0_STR_LSB +: 2]; // RL5
	assign port_a_drive_level_out = pa_lvl_q;
	assign port_b_drive_level_out = pb_lvl_q;
	assign port_c_drive_level_out = pc_lvl_q;
	assign wake_out = wake_q;

endmodule

`default_nettype wire

// ---- verif/iop_port_monitor.sv ----
/*
 * Concurrent checks on the iop_port ports: masks, latch, pulls, levels, wake.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`default_nettype none

module iop_port_monitor (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [iop_pkg::IOP_AW-1:0] mem_addr_in,
	input wire logic mem_wr_in,
	input wire logic mem_rd_in,
	input wire logic [iop_pkg::IOP_DW-1:0] mem_wdata_in,
	input wire logic [iop_pkg::IOP_DW-1:0] mem_rdata_out,
	// Port A and core state
	input wire logic halted_in,
	input wire logic [7:0] port_a_gpio_sel_in,
	input wire logic [7:0] port_a_open_drain_in,
	input wire logic [7:0] port_a_pin_out,
	input wire logic [7:0] port_a_pin_oe_out,
	input wire logic [7:0] port_a_pull_high_out,
	input wire logic [iop_pkg::IOP_LVW-1:0] port_a_drive_level_out,
	// Port D lines and wake
	input wire logic [1:0] port_d0_pull_strength_out,
	input wire logic [1:0] port_d1_pull_strength_out,
	input wire logic [1:0] port_d_pin_direction_out,
	input wire logic wake_out
);
	import iop_pkg::*;

	logic [15:0] oe_x; // Enable doubled per pin
	logic [3:0] wd_nib; // Low nibble of write data, kept for $past
	assign wd_nib = mem_wdata_in[3:0];

	// Level bits may only be set where the pin is driven
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			oe_x[2*i +: 2] = {2{port_a_pin_oe_out[i]}};
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_unmapped_reads_zero: assert property (
		mem_rd_in && mem_addr_in > IOP_OFS_SRC_HIGH |=> mem_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_pd_dir_unused: assert property (
		mem_rd_in && mem_addr_in == IOP_OFS_PD_DIR |=> mem_rdata_out[7:2] == 6'h00)
		else $error("port d direction upper bits not zero");
	a_nibble_regs_unused: assert property (
		mem_rd_in && (mem_addr_in == IOP_OFS_PD_STRENGTH || mem_addr_in == IOP_OFS_SRC_HIGH)
		|=> mem_rdata_out[7:4] == 4'h0)
		else $error("nibble register upper bits not zero");
	a_latch_holds: assert property (
		!(mem_wr_in && mem_addr_in == IOP_OFS_PA_DATA) |=> ##1 $stable(port_a_pin_out))
		else $error("port a latch changed without write");
	a_data_reaches_pin: assert property (
		mem_wr_in && mem_addr_in == IOP_OFS_PA_DATA
		|=> ##1 port_a_pin_out == $past(mem_wdata_in, 2))
		else $error("port a latch not loaded");
	a_strength_follows: assert property (
		mem_wr_in && mem_addr_in == IOP_OFS_PD_STRENGTH
		|=> ##1 {port_d1_pull_strength_out, port_d0_pull_strength_out} == $past(wd_nib, 2))
		else $error("pull strength outputs wrong");
	a_pull_needs_mode: assert property (
		(port_a_pull_high_out & ~$past(port_a_gpio_sel_in) & ~$past(port_a_open_drain_in))
		== 8'h00)
		else $error("pull on pin of other function");
	a_pull_off_driven: assert property (
		(port_a_pull_high_out & port_a_pin_oe_out & ~$past(port_a_open_drain_in)) == 8'h00)
		else $error("pull on cmos output");
	a_level_cmos_only: assert property (
		(port_a_drive_level_out & ~oe_x) == 16'h0000 && port_a_drive_level_out[11:8] == 4'h0)
		else $error("drive level on non output pin");
	a_wake_needs_halt: assert property (
		wake_out |-> $past(halted_in) && ($past(port_a_gpio_sel_in) & ~port_a_pin_oe_out) != 8'h00)
		else $error("wake without halted input pin");
	a_reset_state: assert property (
		$fell(reset_in) |-> port_a_pin_oe_out == 8'h00 && port_a_pull_high_out == 8'h00
		&& port_d_pin_direction_out == 2'h3 && !wake_out)
		else $error("outputs not at reset state");
endmodule

bind iop_port iop_port_monitor i_mon (.*);

`default_nettype wire

// ---- verif/iop_pin_model.sv ----
/*
 * Eight port pins: outside driver, port drive, weak pull, else floating.
 * Assumes one instance per port, clocked by the system clock.
 */
`default_nettype none

module iop_pin_model (
	// Clock
	input wire logic clk_in,
	// Port side
	input wire logic [7:0] drive_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] pull_in,
	// Outside driver
	input wire logic [7:0] ext_in,
	input wire logic [7:0] ext_en_in,
	// Resolved pad level
	output logic [7:0] pin_out
);
	logic alt_q; // Floating lines toggle so a stale value never passes

	initial alt_q = 1'b0;
	always @(posedge clk_in) alt_q <= ~alt_q;

	// Outside driver wins a fight, as a stiff source would
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (ext_en_in[i]) pin_out[i] = ext_in[i];
			else if (oe_in[i]) pin_out[i] = drive_in[i];
			else if (pull_in[i]) pin_out[i] = 1'b1;
			else pin_out[i] = alt_q ^ i[0];
		end
	end
endmodule

`default_nettype wire

// ---- verif/tb_iop_port.sv ----
/*
 * Self-checking bench for iop_port: register tasks, pin models, tests.
 * Assumes the monitor is bound in by its own file.
 */
`default_nettype none

module tb_iop_port;
	timeunit 1ns;
	timeprecision 1ps;
	import iop_pkg::*;

	logic clk_in, reset_in, wr_en, rd_en, halted, irc, wake;
	logic [7:0] addr, wdata, rdata, gs_a, gs_b, gs_c, od_a, od_b, od_c, ext_a, exten_a;
	logic [7:0] pin_a, pin_b, pin_c, out_a, out_b, out_c, oe_a, oe_b, oe_c, pu_a, pu_b, pu_c;
	logic [1:0] pd_dir, str0, str1, k0, k1, k2, k3;
	logic [15:0] lv_a, lv_b, lv_c;
	int fails, checks_done, cycles;
	// Reset contents and fill-test values
	localparam logic [7:0] RST [14] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
		8'hFF, 8'hFF, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FILL [14] = '{8'hFF, 8'hFF, 8'hFF, 8'hCF, 8'hFF, 8'hF7, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	iop_port i_dut (.clk_in(clk_in), .reset_in(reset_in), .mem_addr_in(addr),
		.mem_wr_in(wr_en), .mem_rd_in(rd_en), .mem_wdata_in(wdata), .mem_rdata_out(rdata),
		.halted_in(halted), .input_read_control_in(irc), .port_a_gpio_sel_in(gs_a),
		.port_a_open_drain_in(od_a), .port_b_gpio_sel_in(gs_b), .port_b_open_drain_in(od_b),
		.port_c_gpio_sel_in(gs_c), .port_c_open_drain_in(od_c), .port_a_pin_in(pin_a),
		.port_a_pin_out(out_a), .port_a_pin_oe_out(oe_a), .port_b_pin_in(pin_b),
		.port_b_pin_out(out_b), .port_b_pin_oe_out(oe_b), .port_c_pin_in(pin_c),
		.port_c_pin_out(out_c), .port_c_pin_oe_out(oe_c), .port_a_pull_high_out(pu_a),
		.port_b_pull_high_out(pu_b), .port_c_pull_high_out(pu_c),
		.port_d_pin_direction_out(pd_dir), .port_d0_pull_strength_out(str0),
		.port_d1_pull_strength_out(str1), .port_a_drive_level_out(lv_a),
		.port_b_drive_level_out(lv_b), .port_c_drive_level_out(lv_c), .wake_out(wake));

	// Port A driver is steerable; B and C held high
	iop_pin_model i_pa (.clk_in(clk_in), .drive_in(out_a), .oe_in(oe_a), .pull_in(pu_a),
		.ext_in(ext_a), .ext_en_in(exten_a), .pin_out(pin_a));
	iop_pin_model i_pb (.clk_in(clk_in), .drive_in(out_b), .oe_in(oe_b), .pull_in(pu_b),
		.ext_in(8'hFF), .ext_en_in(8'hFF), .pin_out(pin_b));
	iop_pin_model i_pc (.clk_in(clk_in), .drive_in(out_c), .oe_in(oe_c), .pull_in(pu_c),
		.ext_in(8'hFF), .ext_en_in(8'hFF), .pin_out(pin_c));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Hang guard, far above the run's length
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// One write strobe; taken at the second edge
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_in) #1;
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk_in) #1;
		wr_en = 1'b0;
	endtask

	// Read data is valid just after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in) #1;
		addr = a;
		rd_en = 1'b1;
		@(posedge clk_in) #1;
		rd_en = 1'b0;
		chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdata});
	endtask

	// Expected levels: group code on cmos pins
	function automatic logic [15:0] lvl(input logic [7:0] cm, g1,
		input logic [1:0] c1, input logic [7:0] g2, input logic [1:0] c2);
		lvl = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (cm[i] && g1[i]) lvl[2*i +: 2] = c1;
			else if (cm[i] && g2[i]) lvl[2*i +: 2] = c2;
		end
	endfunction

	// Pulls a port A pin low, counts wake pulses
	task automatic wake_try(input int pin, input logic hv, input logic [7:0] gs, input int exp);
		int seen = 0;
		halted = hv;
		gs_a = gs;
		ext_a = 8'hFF;
		wait_cyc(4);
		ext_a[pin] = 1'b0;
		repeat (6) begin
			@(posedge clk_in) #1;
			if (wake === 1'b1) seen++;
		end
		chk("wake pulses", 16'(exp), 16'(seen));
		halted = 1'b0;
	endtask

	initial begin
		{reset_in, wr_en, rd_en, halted, irc, addr, wdata} = {1'b1, 20'h00000};
		{gs_a, gs_b, gs_c, od_a, od_b, od_c, ext_a, exten_a} = {24'hFFFFFF, 24'h0, 16'hFFFF};
		repeat (16) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		wait_cyc(3);
		chk("port a latch", 16'h00FF, {8'h00, out_a});
		for (int i = 0; i < 14; i++) rd(8'(i), RST[i]);
		rd(8'h20, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 14; i++) wr(8'(i), FILL[i]);
		wr(8'h20, 8'h5A);
		for (int i = 0; i < 14; i++) rd(8'(i), FILL[i] & (i == 10 ? 8'h03 :
			(i == 11 || i == 13) ? 8'h0F : 8'hFF));
		rd(8'h20, 8'h00);
		$display("test unused bits done");
		ext_a = 8'hA5;
		wr(IOP_OFS_PA_DATA, 8'h5A);
		wait_cyc(3);
		rd(IOP_OFS_PA_DATA, 8'hA5);
		wr(IOP_OFS_PA_DIR, 8'h00);
		exten_a = 8'h00;
		wait_cyc(2);
		chk("port a drive", 16'h005A, {8'h00, out_a});
		chk("port a enable", 16'h00FF, {8'h00, oe_a});
		ext_a = 8'h0F;
		exten_a = 8'hFF;
		wait_cyc(3);
		rd(IOP_OFS_PA_DATA, 8'h5A);
		irc = 1'b1;
		rd(IOP_OFS_PA_DATA, 8'h0F);
		irc = 1'b0;
		chk("port a drive", 16'h005A, {8'h00, out_a});
		$display("test latch done");
		wr(IOP_OFS_PA_DIR, 8'h0F);
		gs_a = 8'h3C;
		od_a = 8'h81;
		wait_cyc(2);
		chk("port a pull", 16'h008D, {8'h00, pu_a});
		chk("port b pull", 16'h00F7, {8'h00, pu_b});
		wr(IOP_OFS_PA_PULL, 8'h00);
		wait_cyc(2);
		chk("port a pull", 16'h0000, {8'h00, pu_a});
		$display("test pull-high done");
		for (int c = 0; c < 16; c++) begin
			wr(IOP_OFS_PD_STRENGTH, {4'hA, 4'(c)});
			wait_cyc(1);
			chk("port d strength", 16'(c), {12'h000, str1, str0});
		end
		wr(IOP_OFS_PD_DIR, 8'h00);
		wait_cyc(1);
		chk("port d direction", 16'h0000, {14'h0, pd_dir});
		$display("test port d done");
		gs_a = 8'hFF;
		od_a = 8'h80;
		wr(IOP_OFS_PA_DIR, 8'h00);
		wr(IOP_OFS_PB_DIR, 8'h04);
		wr(IOP_OFS_PC_DIR, 8'h0F);
		for (int c = 0; c < 4; c++) begin
			k0 = 2'(c);
			k1 = k0 + 2'h1;
			k2 = k0 + 2'h2;
			k3 = k0 + 2'h3;
			wr(IOP_OFS_SRC_LOW, {k3, k2, k1, k0});
			wr(IOP_OFS_SRC_HIGH, {4'h0, k1, k0});
			wait_cyc(1);
			chk("port a level", lvl(8'h7F, 8'h0F, k0, 8'hC0, k1), lv_a);
			chk("port b level", lvl(8'hFB, 8'hF0, k3, 8'h01, k2), lv_b);
			chk("port c level", lvl(8'hF0, 8'hF0, k1, 8'h0F, k0), lv_c);
		end
		chk("port b c enable", 16'hFBF0, {oe_b, oe_c});
		$display("test source current done");
		od_a = 8'h00;
		wr(IOP_OFS_PA_DIR, 8'hCF);
		wr(IOP_OFS_PA_WAKE, 8'h01);
		wake_try(0, 1'b1, 8'hFF, 1);
		wake_try(7, 1'b1, 8'hFF, 0);
		wake_try(0, 1'b0, 8'hFF, 0);
		wake_try(0, 1'b1, 8'hFE, 0);
		$display("test wake-up done");
		close_out();
	end
endmodule

`default_nettype wire
